/* File: hw/eii_top.sv */
// Top of the external interrupt input block with its AHB-Lite register slave.
// Assumes a single AHB-Lite master; port pins are asynchronous; vector acks come from the core on clk.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module eii_top #(
  parameter int PINS = 8
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic      [31:0]     hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  input  wire logic [PINS-1:0] port_pins,
  input  wire logic [1:0]      vector_ack,
  output logic      [1:0]      line_request,
  output logic      [7:0]      prio_level_two,
  output logic                 irq
);

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] prio_high;
  logic [7:0] prio_low;
  logic [7:0] line_cfg;
  logic [1:0] trig;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;

  eii_line_if lif_a ();
  eii_line_if lif_b ();

  assign lif_a.pin_select   = line_cfg[eii_pkg::CFG_A_SEL_LSB +: 3];
  assign lif_a.polarity     = line_cfg[eii_pkg::CFG_A_POL_BIT];
  assign lif_a.trigger_type = trig[0];
  assign lif_a.vector_ack   = vector_ack[0];
  assign lif_b.pin_select   = line_cfg[eii_pkg::CFG_B_SEL_LSB +: 3];
  assign lif_b.polarity     = line_cfg[eii_pkg::CFG_B_POL_BIT];
  assign lif_b.trigger_type = trig[1];
  assign lif_b.vector_ack   = vector_ack[1];

  eii_line #(.PINS(PINS)) u_line_a (
    .clk       (clk),
    .rst_n     (rst_n),
    .port_pins (port_pins),
    .lif       (lif_a)
  );

  eii_line #(.PINS(PINS)) u_line_b (
    .clk       (clk),
    .rst_n     (rst_n),
    .port_pins (port_pins),
    .lif       (lif_b)
  );

  // ****************************************
  // AHB-Lite address phase capture
  // ****************************************
  logic                      wr_pend;
  logic [eii_pkg::ADDR_W-1:0] wr_addr;

  wire logic accept   = hsel & hready & htrans[1];
  wire logic rd_take  = accept & ~hwrite;
  wire logic wr_take  = accept & hwrite;
  wire logic [eii_pkg::ADDR_W-1:0] a_addr = haddr[eii_pkg::ADDR_W-1:0];

  // A write is stored in the data phase; zero wait states, so hreadyout stays high.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= wr_take;
      wr_addr <= a_addr;
    end
  end

  wire logic wr_high = wr_pend & (wr_addr == eii_pkg::ADDR_PRIO_HIGH_TWO);
  wire logic wr_low  = wr_pend & (wr_addr == eii_pkg::ADDR_PRIO_LOW_TWO);
  wire logic wr_cfg  = wr_pend & (wr_addr == eii_pkg::ADDR_LINE_CFG);
  wire logic wr_timer_control_reg = wr_pend & (wr_addr == eii_pkg::ADDR_TIMER_CTRL);
  wire logic wr_stat = wr_pend & (wr_addr == eii_pkg::ADDR_IRQ_STATUS);
  wire logic wr_mask = wr_pend & (wr_addr == eii_pkg::ADDR_IRQ_MASK);

  // ****************************************
  // Configuration registers
  // ****************************************
  // Upper four bits of both priority registers are reserved and kept at zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prio_high <= eii_pkg::RST_PRIO;
      prio_low  <= eii_pkg::RST_PRIO;
      line_cfg  <= eii_pkg::RST_LINE_CFG;
      trig      <= eii_pkg::RST_TRIG;
      irq_mask  <= eii_pkg::RST_MASK;
    end else begin
      if (wr_high) prio_high <= {4'h0, hwdata[3:0]};
      if (wr_low)  prio_low  <= {4'h0, hwdata[3:0]};
      if (wr_cfg)  line_cfg  <= hwdata[7:0];
      if (wr_timer_control_reg) trig      <= {hwdata[eii_pkg::TIMER_CONTROL_REG_B_TRIG], hwdata[eii_pkg::TIMER_CONTROL_REG_A_TRIG]};
      if (wr_mask) irq_mask  <= hwdata[1:0];
    end
  end

  // ****************************************
  // Sticky status and interrupt
  // ****************************************
  wire logic [1:0] events      = {lif_b.edge_event, lif_a.edge_event};
  wire logic [1:0] clr_bits    = wr_stat ? hwdata[1:0] : 2'h0;
  wire logic [1:0] next_status = events | (irq_status & ~clr_bits);

  // Set wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_status <= 2'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_status;
      irq        <= |(next_status & irq_mask);
    end
  end

  // ****************************************
  // Read data and outputs
  // ****************************************
  wire logic [7:0] timer_control_reg_view = {4'h0, lif_b.pending, trig[1], lif_a.pending, trig[0]};
  wire logic [7:0] rd_mux =
    (a_addr == eii_pkg::ADDR_PRIO_HIGH_TWO) ? prio_high :
    (a_addr == eii_pkg::ADDR_PRIO_LOW_TWO)  ? prio_low  :
    (a_addr == eii_pkg::ADDR_LINE_CFG)      ? line_cfg  :
    (a_addr == eii_pkg::ADDR_TIMER_CTRL)    ? timer_control_reg_view :
    (a_addr == eii_pkg::ADDR_IRQ_STATUS)    ? {6'h00, irq_status} :
    (a_addr == eii_pkg::ADDR_IRQ_MASK)      ? {6'h00, irq_mask} : 8'h00;
  wire logic [7:0] next_prio = {prio_high[3], prio_low[3], prio_high[2], prio_low[2],
                                prio_high[1], prio_low[1], prio_high[0], prio_low[0]};

  // Unmapped reads return zero; the response is always OKAY.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata         <= 32'h0000_0000;
      hreadyout      <= 1'b1;
      hresp          <= 1'b0;
      line_request   <= 2'h0;
      prio_level_two <= 8'h00;
    end else begin
      if (rd_take) hrdata <= {24'h00_0000, rd_mux};
      hreadyout      <= 1'b1;
      hresp          <= 1'b0;
      line_request   <= {lif_b.pending, lif_a.pending};
      prio_level_two <= next_prio;
    end
  end

  cfg_reset_a: assert property (@(posedge clk) $rose(rst_n) |-> line_cfg == 8'h01)
    else $error("cfg reset wrong");
  prio_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 prio_level_two[7:6] == $past({prio_high[3], prio_low[3]})) else $error("prio pair wrong");
  high_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_high |=> prio_high == {4'h0, $past(hwdata[3:0])}) else $error("prio high write lost");
  timer_control_reg_pend_a: assert property (@(posedge clk) disable iff (!rst_n)
    timer_control_reg_view[3] == lif_b.pending && timer_control_reg_view[1] == lif_a.pending) else $error("pending bits misplaced");
  trig_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_timer_control_reg |=> trig == {$past(hwdata[2]), $past(hwdata[0])}) else $error("trigger write lost");
  // The antecedent skips the release edge, where the flop was still being reset.
  req_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> line_request == $past({lif_b.pending, lif_a.pending})) else $error("request lag wrong");

endmodule : eii_top
`default_nettype wire

/* File: shared/eii_pkg.sv */
// Package for the external interrupt input block: offsets, field positions, reset values.
// Assumes an AHB-Lite register bus with 32-bit data, one register per aligned word.
package eii_pkg;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  // Printed offsets are not all multiples of four, so they are kept as indices.
  localparam logic [7:0] IDX_PRIO_HIGH_TWO = 8'h86;
  localparam logic [7:0] IDX_LINE_CFG      = 8'hE4;
  localparam logic [7:0] IDX_TIMER_CTRL    = 8'h88;
  localparam logic [7:0] IDX_PRIO_LOW_TWO  = 8'hBF;
  localparam logic [7:0] IDX_IRQ_STATUS    = 8'hF0;
  localparam logic [7:0] IDX_IRQ_MASK      = 8'hF1;
  localparam logic [7:0] IDX_VECTOR_ACK    = 8'hF2;
  localparam int         ADDR_W            = 10;
  localparam logic [9:0] ADDR_PRIO_HIGH_TWO = {IDX_PRIO_HIGH_TWO, 2'b00};
  localparam logic [9:0] ADDR_LINE_CFG      = {IDX_LINE_CFG, 2'b00};
  localparam logic [9:0] ADDR_TIMER_CTRL    = {IDX_TIMER_CTRL, 2'b00};
  localparam logic [9:0] ADDR_PRIO_LOW_TWO  = {IDX_PRIO_LOW_TWO, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STATUS    = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK      = {IDX_IRQ_MASK, 2'b00};
  localparam logic [9:0] ADDR_VECTOR_ACK    = {IDX_VECTOR_ACK, 2'b00};

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_A_SEL_LSB  = 0;
  localparam int CFG_A_POL_BIT  = 3;
  localparam int CFG_B_SEL_LSB  = 4;
  localparam int CFG_B_POL_BIT  = 7;
  localparam int TIMER_CONTROL_REG_A_TRIG    = 0;
  localparam int TIMER_CONTROL_REG_A_PEND    = 1;
  localparam int TIMER_CONTROL_REG_B_TRIG    = 2;
  localparam int TIMER_CONTROL_REG_B_PEND    = 3;
  localparam int PRIO_FIELD_W   = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_LINE_CFG   = 8'h01;
  localparam logic [7:0] RST_PRIO       = 8'h00;
  localparam logic [1:0] RST_TRIG       = 2'h0;
  localparam logic [1:0] RST_MASK       = 2'h0;

endpackage : eii_pkg

/* File: shared/eii_line_if.sv */
// Interface carrying one line's conditioning controls and results between main module and line module.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface eii_line_if;
  logic [2:0] pin_select;
  logic       polarity;
  logic       trigger_type;
  logic       vector_ack;
  logic       pending;
  logic       edge_event;
  modport ctrl (output pin_select, output polarity, output trigger_type, output vector_ack,
                input pending, input edge_event);
  modport line (input pin_select, input polarity, input trigger_type, input vector_ack,
                output pending, output edge_event);
endinterface : eii_line_if
`default_nettype wire

/* File: hw/eii_line.sv */
// One external interrupt line: pin synchroniser, pin select, polarity, edge or level pending flag.
// Assumes port pins are asynchronous and the acknowledge pulse is on the same clock.
`timescale 1ns/100ps
`default_nettype none
module eii_line #(
  parameter int PINS = 8
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic [PINS-1:0] port_pins,
  eii_line_if.line             lif
);

  // ****************************************
  // Synchroniser and selection
  // ****************************************
  logic [PINS-1:0] sync_meta;
  logic [PINS-1:0] sync_pins;
  logic            active_q;

  // All pins are synchronised so a select change never samples a raw pin; pins are only read.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_meta <= '0;
      sync_pins <= '0;
    end else begin
      sync_meta <= port_pins;
      sync_pins <= sync_meta;
    end
  end

  wire logic selected_pin = sync_pins[lif.pin_select];
  wire logic active_now   = selected_pin ~^ lif.polarity;
  wire logic active_edge  = active_now & ~active_q;

  // ****************************************
  // Pending flag
  // ****************************************
  logic edge_flag;
  // In level mode the latch is held clear, so a switch to edge mode never shows an edge seen earlier.
  wire logic next_edge_flag = lif.trigger_type & (active_edge | (edge_flag & ~lif.vector_ack));

  // An edge in the acknowledge cycle wins so no request is lost.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_q  <= 1'b1; // Matches the reset view of an active-low line, so no false edge follows reset.
      edge_flag <= 1'b0;
    end else begin
      active_q  <= active_now;
      edge_flag <= next_edge_flag;
    end
  end

  assign lif.pending    = lif.trigger_type ? edge_flag : active_now;
  assign lif.edge_event = lif.trigger_type ? active_edge : (active_now & ~active_q);

  pend_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    !lif.trigger_type |-> lif.pending == active_now) else $error("level pending mismatch");
  edge_sets_a: assert property (@(posedge clk) disable iff (!rst_n)
    lif.trigger_type && active_edge |=> edge_flag) else $error("edge did not set pending");
  ack_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
    lif.vector_ack && !active_edge |=> !edge_flag) else $error("ack did not clear");
  sync_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |-> ##2 sync_pins == $past(port_pins, 2)) else $error("sync depth wrong");

endmodule : eii_line
`default_nettype wire

/* File: dv/eii_irq_source.sv */
// Behavioural model of the external devices that drive the port-0 interrupt pins.
// Assumes one bench process calls drive() and that clk is the block's system clock.
`timescale 1ns/100ps
`default_nettype none
module eii_irq_source (
  input  wire logic       clk,
  output var  logic [7:0] pins
);
  // ****************************************
  // Pin driver
  // ****************************************
  // Pins idle low and only move on request, so a level request is held until seen.
  initial pins = 8'h00;
  // A new level is set just after an edge and then left standing; the wait lets the
  // two-stage synchroniser and the flags settle; the bench acknowledges only in edge mode,
  // where a stale level (pin 5 stays low through line b's ack) raises no second request.
  task automatic drive(input logic [7:0] v);
    @(posedge clk);
    pins <= v;
    repeat (4) @(posedge clk);
  endtask : drive
endmodule : eii_irq_source
`default_nettype wire

/* File: dv/test_external_interrupt_inputs.sv */
// Self-checking bench for the external interrupt input block, driven over AHB-Lite.
// Assumes the block is the only slave, so hready is tied to its hreadyout.
`timescale 1ns/100ps
`default_nettype none
module test_external_interrupt_inputs;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans;
  logic [1:0]  vector_ack;
  logic [1:0]  line_request;
  logic [2:0]  hsize;
  logic [7:0]  port_pins;
  logic [7:0]  prio_level_two;
  int          mismatches;
  int          total_checks;

  // ****************************************
  // Clock, bus wiring and instances
  // ****************************************
  // A single slave answers for the whole bus.
  assign hready = hreadyout;
  // The clock runs at 25 MHz.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  eii_irq_source i_src (.clk(clk), .pins(port_pins));
  eii_top #(.PINS(8)) i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port_pins(port_pins), .vector_ack(vector_ack),
    .line_request(line_request), .prio_level_two(prio_level_two), .irq(irq));

  // ****************************************
  // Tasks
  // ****************************************
  // Prints the counts and the verdict; every path out of the run ends here.
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  // Compares with case equality so an unknown never counts as a match.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Waits for hready at a rising edge, with a bound so a stuck slave cannot hang the run.
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        mismatches++;
        conclude();
      end
      @(posedge clk);
    end
  endtask : wait_rdy
  // One single word transfer: address phase, then data phase; read data is taken at its end.
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    htrans <= 2'b10;
    haddr  <= {22'h0, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_rdy();
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    check(rd, {24'h0, exp});
  endtask : rchk
  // The core's vectoring pulse lasts one cycle.
  task automatic ack(input logic [1:0] m);
    @(posedge clk);
    vector_ack <= m;
    @(posedge clk);
    vector_ack <= 2'b00;
  endtask : ack

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [2:0] sel;
    {hsel, hwrite, htrans, vector_ack, rst_n} = '0;
    haddr = '0;
    hwdata = '0;
    hsize = 3'b010;
    mismatches = 0;
    total_checks = 0;
    hsel = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // Reset state: line a watches pin 1 and line b pin 0, both active low in level mode, so low pins raise both.
    rchk(eii_pkg::ADDR_LINE_CFG, 8'h01);
    rchk(eii_pkg::ADDR_PRIO_HIGH_TWO, 8'h00);
    rchk(eii_pkg::ADDR_TIMER_CTRL, 8'h0A);
    // Pins already active at reset are no edge, so no status bit may be set.
    rchk(eii_pkg::ADDR_IRQ_STATUS, 8'h00);
    rchk(eii_pkg::ADDR_IRQ_MASK, 8'h00);
    rchk(10'h004, 8'h00);
    check({31'h0, hresp}, 32'h0);
    // Priority MSBs join the LSBs pairwise; the upper nibble reads zero.
    wr(eii_pkg::ADDR_PRIO_HIGH_TWO, 8'hFF);
    rchk(eii_pkg::ADDR_PRIO_HIGH_TWO, 8'h0F);
    wr(eii_pkg::ADDR_PRIO_LOW_TWO, 8'h05);
    rchk(eii_pkg::ADDR_PRIO_LOW_TWO, 8'h05);
    check({24'h0, prio_level_two}, 32'hBB);
    // Level mode on every pin: both lines watch pin i, a active high, b active low,
    // with all other pins opposite so a wrong selection shows.
    for (int i = 0; i < 8; i++) begin
      sel = i[2:0];
      wr(eii_pkg::ADDR_LINE_CFG, {1'b0, sel, 1'b1, sel});
      rchk(eii_pkg::ADDR_LINE_CFG, {1'b0, sel, 1'b1, sel});
      i_src.drive(~(8'h01 << sel));
      rchk(eii_pkg::ADDR_TIMER_CTRL, 8'h08);
      check({30'h0, line_request}, 32'h2);
      i_src.drive(8'h01 << sel);
      rchk(eii_pkg::ADDR_TIMER_CTRL, 8'h02);
      check({30'h0, line_request}, 32'h1);
      check({31'h0, irq}, 32'h0);
    end
    // Edge mode: a on pin 2 rising, b on pin 5 falling; flags latch until vectoring.
    i_src.drive(8'h20);
    wr(eii_pkg::ADDR_LINE_CFG, 8'h5A);
    wr(eii_pkg::ADDR_TIMER_CTRL, 8'h05);
    wr(eii_pkg::ADDR_IRQ_STATUS, 8'h03);
    rchk(eii_pkg::ADDR_IRQ_STATUS, 8'h00);
    rchk(eii_pkg::ADDR_TIMER_CTRL, 8'h05);
    i_src.drive(8'h24);
    rchk(eii_pkg::ADDR_TIMER_CTRL, 8'h07);
    check({30'h0, line_request}, 32'h1);
    i_src.drive(8'h20);
    rchk(eii_pkg::ADDR_TIMER_CTRL, 8'h07);
    check({31'h0, irq}, 32'h0);
    wr(eii_pkg::ADDR_IRQ_MASK, 8'h01);
    rchk(eii_pkg::ADDR_IRQ_STATUS, 8'h01);
    check({31'h0, irq}, 32'h1);
    ack(2'b01);
    rchk(eii_pkg::ADDR_TIMER_CTRL, 8'h05);
    i_src.drive(8'h00);
    rchk(eii_pkg::ADDR_TIMER_CTRL, 8'h0D);
    check({30'h0, line_request}, 32'h2);
    wr(eii_pkg::ADDR_IRQ_STATUS, 8'h01);
    rchk(eii_pkg::ADDR_IRQ_STATUS, 8'h02);
    check({31'h0, irq}, 32'h0);
    wr(eii_pkg::ADDR_IRQ_MASK, 8'h03);
    rchk(eii_pkg::ADDR_IRQ_MASK, 8'h03);
    check({31'h0, irq}, 32'h1);
    ack(2'b10);
    rchk(eii_pkg::ADDR_TIMER_CTRL, 8'h05);
    wr(eii_pkg::ADDR_IRQ_STATUS, 8'h02);
    rchk(eii_pkg::ADDR_IRQ_STATUS, 8'h00);
    check({31'h0, irq}, 32'h0);
    conclude();
  end
endmodule : test_external_interrupt_inputs
`default_nettype wire
